// ---- fau_add_unit.sv ----
// What this block does
// RULE1: four-bit condition code register kept here, part of status word
// RULE2: every add updates the condition code: exception, sign, zero
// RULE3: greater, less, zero judged on result as two's complement number
// RULE4: memory byte add zero-extends byte, adds to register, writes register
// RULE5: word results: bit1 exception, bit2 positive, bit3 negative, bit4 zero
// RULE6: memory doubleword add: low word first, carry into high, into R,R+1
// RULE7: register add: source plus destination into destination, codes from it
// RULE8: masked register add: sum ANDed with mask register before write
// RULE9: register-to-memory byte add writes only low result byte to memory
// RULE10: after that byte add, bit4 means full 32-bit sum zero
// RULE11: register-to-memory halfword add: low register half plus memory half
// RULE12: after halfword add, bit4 means stored halfword zero
// RULE13: register-to-memory word add writes sum to memory, codes from it
// RULE14: register-to-memory doubleword add: pair plus memory, low first, stored
// RULE15: base codes decode as byte, word register-to-memory and memory word add
// RULE16: memory forms: opcode, register, index, indirect, address fields
// RULE17: register forms: destination, source, augmenting code fields
// RULE18: exception when equal-sign operands give a result of the other sign
`timescale 1ns/100ps
module fau_add_unit #(
    parameter int WIDTH = fau_pkg::DATA_W
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             ce,
    input  wire logic             start,
    input  wire fau_pkg::fau_req_t req,
    output fau_pkg::fau_rsp_t     rsp
);
    import fau_pkg::*;

    if (WIDTH != DATA_W) begin : g_chk
        $error("fau_add_unit: only a 32-bit datapath is supported");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} fau_state_t;

    fau_state_t  stateQ, stateD;
    fau_req_t    reqQ, reqD;
    fau_kind_t   kindQ, kindD;
    fau_rsp_t    rspQ, rspD;
    logic [31:0] lowQ, lowD;
    logic        carryQ, carryD;
    logic [31:0] addA, addB, addSum, res;
    logic        addCin, addCout, addOvf;
    logic [4:0]  laneSh;
    logic [31:0] laneMask;

    // ***************************************************
    // decode of a request word
    // ***************************************************
    function automatic fau_kind_t decodeKind(input logic [31:0] iw);
        logic [5:0] opc;
        logic [3:0] aug;
        logic       fmt;
        logic [1:0] sz;
        opc = iw[OPC_LSB +: OPC_W]; // RULE16
        aug = iw[AUG_LSB +: AUG_W]; // RULE17
        fmt = iw[FMT_BIT];
        sz  = iw[1:0];
        decodeKind = K_BAD;
        case (opc)
            OPC_ADD_MEM: begin // RULE15
                if (fmt) decodeKind = K_ADD_MEM_BYTE;
                else if (sz == 2'b00) decodeKind = K_ADD_MEM_WORD;
                else if (sz == 2'b10) decodeKind = K_ADD_MEM_DWORD;
                else decodeKind = K_BAD;
            end
            OPC_ADD_RTM: begin // RULE15
                if (fmt) decodeKind = K_RTM_BYTE;
                else if (sz[0]) decodeKind = K_RTM_HALF;
                else if (sz == 2'b00) decodeKind = K_RTM_WORD;
                else decodeKind = K_RTM_DWORD;
            end
            OPC_REG_REG: begin
                if (aug == AUG_ADD_REG) decodeKind = K_ADD_REG;
                else if (aug == AUG_ADD_MSK) decodeKind = K_ADD_REG_MASKED;
                else decodeKind = K_BAD;
            end
            default: decodeKind = K_BAD;
        endcase
    endfunction : decodeKind

    // condition code of a word result
    function automatic fau_cc_t wordCc(input logic [31:0] r, input logic exc);
        fau_cc_t c;
        c.exc = exc;
        c.lt  = r[31]; // RULE3
        c.eq  = (r == WORD_ZERO);
        c.gt  = !r[31] && (r != WORD_ZERO);
        wordCc = c;
    endfunction : wordCc

    // ***************************************************
    // shared adder
    // ***************************************************
    fau_adder #(
        .WIDTH (DATA_W)
    ) u_adder (
        .a    (addA),
        .b    (addB),
        .cin  (addCin),
        .sum  (addSum),
        .cout (addCout),
        .ovf  (addOvf)
    );

    // byte lane of the addressed word; byte 0 is the most significant
    always_comb begin
        laneSh   = 5'(({3'b000, ~reqQ.instr[1:0]}) << 3);
        laneMask = 32'h0000_00FF << laneSh;
    end

    // operand steering: low step or high step with the saved carry
    always_comb begin
        addA   = reqQ.regA;
        addB   = reqQ.memHi;
        addCin = 1'b0;
        if (stateQ == ST_HIGH) begin
            addCin = carryQ; // RULE6 RULE14
        end else begin
            case (kindQ)
                K_ADD_MEM_BYTE,
                K_RTM_BYTE:  addB = (reqQ.memHi & laneMask) >> laneSh; // RULE4
                K_ADD_REG,
                K_ADD_REG_MASKED: addB = reqQ.regB; // RULE7
                K_RTM_HALF: begin
                    addA = {16'h0000, reqQ.regA[15:0]}; // RULE11
                    addB = reqQ.instr[1] ? {16'h0000, reqQ.memHi[15:0]}
                                         : {16'h0000, reqQ.memHi[31:16]};
                end
                K_ADD_MEM_DWORD,
                K_RTM_DWORD: begin
                    addA = reqQ.regB; // RULE6 RULE14
                    addB = reqQ.memLo;
                end
                default: addB = reqQ.memHi;
            endcase
        end
    end

    // ***************************************************
    // sequencing and result formation
    // ***************************************************
    always_comb begin
        stateD          = stateQ;
        reqD            = reqQ;
        kindD           = kindQ;
        lowD            = lowQ;
        carryD          = carryQ;
        rspD            = rspQ;
        rspD.done       = 1'b0;
        rspD.badOp      = 1'b0;
        rspD.regWe      = 2'b00;
        rspD.memWe      = 2'b00;
        rspD.memByteEn  = BEN_NONE;
        res             = addSum;
        case (stateQ)
            ST_IDLE: begin
                if (start) begin
                    reqD        = req;
                    kindD       = decodeKind(req.instr);
                    rspD.regNum = req.instr[REG_LSB +: REG_W];
                    if (decodeKind(req.instr) == K_BAD) begin
                        rspD.done  = 1'b1;
                        rspD.badOp = 1'b1; // unsupported code: codes untouched
                    end else begin
                        stateD    = ST_LOW;
                        rspD.busy = 1'b1;
                    end
                end
            end
            ST_LOW: begin
                stateD = ST_IDLE;
                case (kindQ)
                    K_ADD_MEM_DWORD,
                    K_RTM_DWORD: begin
                        lowD   = addSum;
                        carryD = addCout;
                        stateD = ST_HIGH;
                    end
                    K_RTM_BYTE: begin
                        rspD.memWe     = 2'b10;
                        rspD.memByteEn = 4'b1000 >> reqQ.instr[1:0]; // RULE9
                        rspD.memWdHi   = (reqQ.memHi & ~laneMask)
                                       | ((addSum & 32'h0000_00FF) << laneSh);
                        // first three bits left cleared, zero from full sum
                        rspD.cc        = '{exc: 1'b0, gt: 1'b0, lt: 1'b0,
                                           eq: addSum == WORD_ZERO}; // RULE10
                    end
                    K_RTM_HALF: begin
                        rspD.memWe     = 2'b10;
                        rspD.memByteEn = reqQ.instr[1] ? 4'b0011 : 4'b1100; // RULE11
                        rspD.memWdHi   = reqQ.instr[1]
                                       ? {reqQ.memHi[31:16], addSum[15:0]}
                                       : {addSum[15:0], reqQ.memHi[15:0]};
                        rspD.cc        = '{exc: 1'b0, gt: 1'b0, lt: 1'b0,
                                           eq: addSum[15:0] == 16'h0000}; // RULE12
                    end
                    K_RTM_WORD: begin
                        rspD.memWe     = 2'b10; // RULE13
                        rspD.memByteEn = BEN_WORD;
                        rspD.memWdHi   = addSum;
                        rspD.cc        = wordCc(addSum, addOvf);
                    end
                    default: begin
                        // register destinations: byte, word, plain and masked
                        if (kindQ == K_ADD_REG_MASKED) begin
                            res = addSum & reqQ.maskReg; // RULE8
                        end
                        rspD.regWe  = 2'b01; // RULE4 RULE7
                        rspD.regWdA = res;
                        rspD.cc     = wordCc(res, addOvf); // RULE1 RULE2 RULE5
                    end
                endcase
                if (stateD == ST_IDLE) begin
                    rspD.done = 1'b1;
                    rspD.busy = 1'b0;
                end
            end
            ST_HIGH: begin
                // exception from the high half; zero needs both halves
                rspD.cc.exc = addOvf; // RULE18
                rspD.cc.lt  = addSum[31];
                rspD.cc.eq  = (addSum == WORD_ZERO) && (lowQ == WORD_ZERO);
                rspD.cc.gt  = !addSum[31] && !rspD.cc.eq; // RULE3
                if (kindQ == K_ADD_MEM_DWORD) begin
                    rspD.regWe  = 2'b11; // RULE6
                    rspD.regWdA = addSum;
                    rspD.regWdB = lowQ;
                end else begin
                    rspD.memWe     = 2'b11; // RULE14
                    rspD.memByteEn = BEN_WORD;
                    rspD.memWdHi   = addSum;
                    rspD.memWdLo   = lowQ;
                end
                rspD.done = 1'b1;
                rspD.busy = 1'b0;
                stateD    = ST_IDLE;
            end
            default: stateD = ST_IDLE;
        endcase
    end

    // registers; clock enable low freezes everything
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stateQ <= ST_IDLE;
            reqQ   <= '0;
            kindQ  <= K_BAD;
            lowQ   <= WORD_ZERO;
            carryQ <= 1'b0;
            rspQ   <= '0;
        end else if (ce) begin
            stateQ <= stateD;
            reqQ   <= reqD;
            kindQ  <= kindD;
            lowQ   <= lowD;
            carryQ <= carryD;
            rspQ   <= rspD;
        end
    end

    assign rsp = rspQ;

    // ***************************************************
    // checks
    // ***************************************************
    a_zero_flag: assert property (@(posedge clk) disable iff (!reset_n) // RULE5
        rspQ.done && rspQ.regWe == 2'b01 |-> rspQ.cc.eq == (rspQ.regWdA == WORD_ZERO))
        else $error("zero flag does not match register result");

    a_sign_flags: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
        rspQ.done && rspQ.regWe == 2'b01
        |-> rspQ.cc.lt == rspQ.regWdA[31] && !(rspQ.cc.gt && rspQ.cc.lt))
        else $error("sign flags do not match register result");

    a_mask_applied: assert property (@(posedge clk) disable iff (!reset_n) // RULE8
        rspQ.done && kindQ == K_ADD_REG_MASKED
        |-> rspQ.regWdA == ((reqQ.regA + reqQ.regB) & reqQ.maskReg))
        else $error("masked add result wrong");

    a_reg_sum: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
        rspQ.done && kindQ == K_ADD_REG
        |-> rspQ.regWdA == reqQ.regA + reqQ.regB
            && rspQ.cc.exc == (reqQ.regA[31] == reqQ.regB[31] && rspQ.regWdA[31] != reqQ.regA[31]))
        else $error("register add or exception wrong");

    a_byte_lane: assert property (@(posedge clk) disable iff (!reset_n) // RULE9
        rspQ.done && kindQ == K_RTM_BYTE
        |-> rspQ.regWe == 2'b00 && $onehot(rspQ.memByteEn)
            && (rspQ.memWdHi & ~laneMask) == (reqQ.memHi & ~laneMask))
        else $error("byte add touched more than its byte");

    a_half_zero: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
        rspQ.done && kindQ == K_RTM_HALF
        |-> rspQ.cc.eq == (reqQ.instr[1] ? rspQ.memWdHi[15:0] == 16'h0000
                                         : rspQ.memWdHi[31:16] == 16'h0000))
        else $error("halfword zero flag wrong");

    a_word_store: assert property (@(posedge clk) disable iff (!reset_n) // RULE13
        rspQ.done && kindQ == K_RTM_WORD
        |-> rspQ.memWe == 2'b10 && rspQ.memWdHi == reqQ.memHi + reqQ.regA
            && rspQ.cc.eq == (rspQ.memWdHi == WORD_ZERO))
        else $error("register to memory word add wrong");

    a_dword_sum: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
        rspQ.done && kindQ == K_ADD_MEM_DWORD
        |-> {rspQ.regWdA, rspQ.regWdB} == {reqQ.memHi, reqQ.memLo} + {reqQ.regA, reqQ.regB})
        else $error("doubleword add to registers wrong");

    // low step of a stored doubleword must go on to the high step, no early done
    a_dword_steps: assert property (@(posedge clk) disable iff (!reset_n) // RULE14
        stateQ == ST_LOW && ce && kindQ == K_RTM_DWORD
        |=> stateQ == ST_HIGH && !rspQ.done)
        else $error("doubleword store left its low step wrongly");

    // high step ends the store with both words written
    a_dword_store: assert property (@(posedge clk) disable iff (!reset_n) // RULE14
        stateQ == ST_HIGH && ce && kindQ == K_RTM_DWORD
        |=> rspQ.done && rspQ.memWe == 2'b11 && stateQ == ST_IDLE)
        else $error("doubleword store not finished after its high step");

endmodule : fau_add_unit

// ---- fau_add_unit_tb.sv ----
`timescale 1ns/100ps
module fau_add_unit_tb;
    import fau_pkg::*;

    // ***************************************************
    // stimulus, reference state and bookkeeping
    // ***************************************************
    logic        clk;
    logic        reset_n;
    logic        ce;
    logic        start;
    logic [31:0] iw;
    fau_req_t    req;
    fau_rsp_t    rsp;
    logic [31:0] eg [8];
    logic [31:0] em [16];
    logic [3:0]  ecc;
    logic        ebad;
    int          elat;
    logic [15:0] seed;
    int          nErrors;
    int          checked;
    // base codes and the fields that may vary (register, index, word, lane)
    logic [31:0] kBase [12] = '{32'hB808_0000, 32'hB800_0000, 32'hB800_0002, 32'hB800_0001,
                                32'hE808_0000, 32'hE800_0001, 32'hE800_0000, 32'hE800_0002,
                                32'h3800_0000, 32'h3808_0000, 32'h3803_0000, 32'hFC00_0000};
    logic [31:0] kMask [12] = '{32'h03F0_003F, 32'h03F0_003C, 32'h0370_003C, 32'h03F0_003C,
                                32'h03F0_003F, 32'h03F0_003E, 32'h03F0_003C, 32'h0370_003C,
                                32'h03F0_0000, 32'h03F0_0000, 32'h03F0_0000, 32'h03FF_FFFF};

    fau_add_unit i_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .start(start), .req(req), .rsp(rsp));
    fau_opnd_model i_part (.clk(clk), .ce(ce), .instr(iw), .rsp(rsp), .req(req));

    // free-running 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [15:0] nx(input logic [15:0] s);
        nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nx

    function logic [31:0] r32();
        seed = nx(seed);
        r32[31:16] = seed;
        seed = nx(seed);
        r32[15:0] = seed;
    endfunction : r32

    // codes {exc, gt, lt, eq} of a sum whose sign bit is m
    function automatic logic [3:0] cc(input logic [63:0] a, input logic [63:0] b, input logic [63:0] s, input int m);
        cc[3] = (a[m] == b[m]) && (s[m] != a[m]);
        cc[0] = (s == 64'h0);
        cc[1] = s[m];
        cc[2] = !cc[1] && !cc[0];
    endfunction : cc

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            nErrors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("errors=%0d checks=%0d", nErrors, checked);
        if (nErrors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done

    // reference of one instruction on the copied register and memory state
    task automatic model(input logic [31:0] w);
        logic [2:0]  r;
        logic [3:0]  a;
        int          sh;
        logic [31:0] x, y, s, m, bv;
        logic [63:0] p, q, d;
        logic [15:0] h;
        logic [3:0]  c, t;
        r = w[25:23];
        a = w[5:2];
        sh = 24 - 8 * int'(w[1:0]);
        x = eg[r];
        y = em[a];
        bv = (em[a] >> sh) & 32'h0000_00FF;
        p = {eg[r], eg[3'(r + 3'd1)]};
        q = {em[a], em[4'(a + 4'd1)]};
        d = p + q;
        elat = 2;
        ebad = 1'b0;
        case (w[31:26])
            OPC_ADD_MEM: begin
                if (w[19]) y = bv;
                if (w[19] || w[1:0] == 2'b00) begin
                    s = x + y;
                    eg[r] = s;
                    ecc = cc(x, y, s, 31);
                end else if (w[1:0] == 2'b10) begin
                    eg[r] = d[63:32];
                    eg[3'(r + 3'd1)] = d[31:0];
                    ecc = cc(p, q, d, 63);
                    elat = 3;
                end else ebad = 1'b1;
            end
            OPC_ADD_RTM: begin
                if (w[19]) begin
                    s = x + bv;
                    em[a] = (em[a] & ~(32'h0000_00FF << sh)) | ((s & 32'h0000_00FF) << sh);
                    ecc = {3'b000, s == 32'h0000_0000};
                end else if (w[0]) begin
                    sh = w[1] ? 0 : 16;
                    h = 16'(em[a] >> sh) + x[15:0];
                    em[a] = (em[a] & ~(32'h0000_FFFF << sh)) | (32'(h) << sh);
                    ecc = {3'b000, h == 16'h0000};
                end else if (!w[1]) begin
                    s = x + y;
                    em[a] = s;
                    ecc = cc(x, y, s, 31);
                end else begin
                    em[a] = d[63:32];
                    em[4'(a + 4'd1)] = d[31:0];
                    ecc = cc(p, q, d, 63);
                    elat = 3;
                end
            end
            OPC_REG_REG: begin
                y = eg[w[22:20]];
                s = x + y;
                m = s & eg[4];
                c = cc(x, y, s, 31);
                t = cc(64'h0, 64'h0, m, 31);
                if (w[19:16] == AUG_ADD_REG) begin
                    eg[r] = s;
                    ecc = c;
                end else if (w[19:16] == AUG_ADD_MSK) begin
                    eg[r] = m;
                    ecc = {c[3], t[2:0]};
                end else ebad = 1'b1;
            end
            default: ebad = 1'b1;
        endcase
        if (ebad) elat = 1;
    endtask : model

    // one request; hold keeps start up into the busy cycle, which must be ignored
    task automatic run_op(input logic [31:0] w, input bit hold);
        int k;
        eg = i_part.general_register;
        em = i_part.mem;
        model(w);
        k = 0;
        @(posedge clk);
        start <= 1'b1;
        iw <= w;
        ce <= 1'b1;
        repeat (40) begin
            @(posedge clk);
            k = k + (ce ? 1 : 0);
            start <= hold && k == 1;
            ce <= seed[0] | seed[1];
            seed = nx(seed);
            #1;
            if (rsp.done === 1'b1) break;
        end
        chk(k, elat);
        chk(rsp.badOp, ebad);
        chk(rsp.cc, ecc);
        @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        #1;
        chk(rsp.busy, 1'b0);
        for (int i = 0; i < 16; i++) begin
            chk(i_part.mem[i], em[i]);
            if (i < 8) chk(i_part.general_register[i], eg[i]);
        end
    endtask : run_op

    task automatic setv(input int r, input logic [31:0] rv, input int a, input logic [31:0] mv);
        i_part.general_register[r] = rv;
        i_part.mem[a] = mv;
    endtask : setv

    // reset is held ten cycles; all outputs must read zero at its last cycle
    task automatic do_reset();
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (10) @(posedge clk);
        chk(64'(rsp !== '0), 64'h0);
        reset_n <= 1'b1;
        ecc = 4'h0;
    endtask : do_reset

    // watchdog, far beyond the roughly one thousand cycles the run needs
    initial begin
        #(40_000 * 100);
        nErrors++;
        test_done();
    end

    // ***************************************************
    // main sequence
    // ***************************************************
    initial begin
        reset_n = 1'b0;
        ce = 1'b0;
        start = 1'b0;
        iw = 32'h0000_0000;
        nErrors = 0;
        checked = 0;
        ecc = 4'h0;
        seed = 16'h837D;
        for (int i = 0; i < 16; i++) i_part.mem[i] = r32();
        for (int i = 0; i < 8; i++) i_part.general_register[i] = r32();
        do_reset();
        // corners: overflow, zero extension, wrapped sums, carry across words, mask
        setv(1, 32'h7FFF_FFFF, 2, 32'h0000_0001);
        run_op(32'hB880_0008, 1'b0);
        setv(2, 32'hFFFF_FF00, 2, 32'h0000_0080);
        run_op(32'hB908_000B, 1'b0);
        setv(3, 32'hFFFF_FF01, 3, 32'hFF12_3456);
        run_op(32'hE988_000C, 1'b0);
        setv(3, 32'h0000_0001, 3, 32'hFF12_3456);
        run_op(32'hE988_000C, 1'b0);
        setv(5, 32'hFFFF_0001, 4, 32'h1234_FFFF);
        run_op(32'hEA80_0013, 1'b0);
        setv(4, 32'h0000_0000, 6, 32'hFFFF_FFFF);
        setv(5, 32'hFFFF_FFFF, 7, 32'h0000_0001);
        run_op(32'hBA00_001A, 1'b0);
        setv(6, 32'h7FFF_FFFF, 0, 32'h0000_0000);
        setv(7, 32'h0000_0001, 0, 32'h0000_0000);
        setv(4, 32'h0000_FFFF, 0, 32'h0000_0000);
        run_op(32'h3B78_0000, 1'b0);
        // every kind, random fields and operands
        for (int n = 0; n < 16; n++) begin
            for (int j = 0; j < 12; j++) begin
                setv(j % 8, r32(), n, r32());
                run_op(kBase[j] | (r32() & kMask[j]), j == 1 || j == 7);
            end
        end
        do_reset();
        run_op(32'hE800_0002, 1'b0);
        test_done();
    end
endmodule : fau_add_unit_tb

// ---- fau_adder.sv ----
`timescale 1ns/100ps
module fau_adder #(
    parameter int WIDTH = 32
) (
    input  wire logic [WIDTH-1:0] a,
    input  wire logic [WIDTH-1:0] b,
    input  wire logic             cin,
    output logic      [WIDTH-1:0] sum,
    output logic                  cout,
    output logic                  ovf
);

    if (WIDTH < 2) begin : g_chk
        $error("fau_adder: WIDTH must be at least 2");
    end

    // ***************************************************
    // carry chain and signed overflow
    // ***************************************************
    always_comb begin
        {cout, sum} = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
        // same-sign operands giving the other sign
        ovf = (a[WIDTH-1] == b[WIDTH-1]) && (sum[WIDTH-1] != a[WIDTH-1]); // RULE18
    end

endmodule : fau_adder

// ---- fau_opnd_model.sv ----
`timescale 1ns/100ps
module fau_opnd_model (
    input  wire logic              clk,
    input  wire logic              ce,
    input  wire logic [31:0]       instr,
    input  wire fau_pkg::fau_rsp_t rsp,
    output fau_pkg::fau_req_t      req
);
    import fau_pkg::*;

    // ***************************************************
    // register file and operand words of the far side
    // ***************************************************
    logic [31:0] general_register [8];
    logic [31:0] mem [16];
    logic [3:0]  wIdx;

    // word index only; address generation is not modelled
    assign wIdx = instr[5:2];

    // operands follow the instruction at once, like a fetched operand path
    always_comb begin
        req.instr   = instr;
        req.regA    = general_register[instr[25:23]];
        req.regB    = (instr[31:26] == OPC_REG_REG) ? general_register[instr[22:20]] : general_register[3'(instr[25:23] + 3'd1)];
        req.maskReg = general_register[4];
        req.memHi   = mem[wIdx];
        req.memLo   = mem[4'(wIdx + 4'd1)];
    end

    // write-back on enabled edges only, since done stands while ce is low
    always @(posedge clk) begin
        if (rsp.done && ce) begin
            if (rsp.regWe[0]) general_register[rsp.regNum] <= rsp.regWdA;
            if (rsp.regWe[1]) general_register[3'(rsp.regNum + 3'd1)] <= rsp.regWdB;
            for (int k = 0; k < 4; k++) begin
                if (rsp.memWe[1] && rsp.memByteEn[k]) mem[wIdx][8*k +: 8] <= rsp.memWdHi[8*k +: 8];
            end
            if (rsp.memWe[0]) mem[4'(wIdx + 4'd1)] <= rsp.memWdLo;
        end
    end
endmodule : fau_opnd_model

// ---- fau_pkg.sv ----
package fau_pkg;

    // ***************************************************
    // instruction field positions (vector bit numbers, bit 0 is the lsb)
    // ***************************************************
    localparam int OPC_LSB  = 26;   // operation code, 6 bits
    localparam int OPC_W    = 6;
    localparam int REG_LSB  = 23;   // register / destination register, 3 bits
    localparam int REG_W    = 3;
    localparam int IDX_LSB  = 21;   // index selector, 2 bits
    localparam int IND_BIT  = 20;   // indirect flag
    localparam int FMT_BIT  = 19;   // byte format flag of the address field
    localparam int SRC_LSB  = 20;   // source register of register forms
    localparam int AUG_LSB  = 16;   // augmenting operation code, 4 bits
    localparam int AUG_W    = 4;
    localparam int ADDR_W   = 20;   // address field, bits 0..19 of the vector

    // ***************************************************
    // operation codes
    // ***************************************************
    localparam logic [5:0] OPC_ADD_MEM = 6'h2E;   // base code 16'hB800
    localparam logic [5:0] OPC_ADD_RTM = 6'h3A;   // base codes 16'hE800 / 16'hE808
    localparam logic [5:0] OPC_REG_REG = 6'h0E;
    localparam logic [3:0] AUG_ADD_REG = 4'h0;
    localparam logic [3:0] AUG_ADD_MSK = 4'h8;

    // ***************************************************
    // reset values and widths
    // ***************************************************
    localparam int          DATA_W     = 32;
    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
    localparam logic [3:0]  BEN_WORD   = 4'hF;
    localparam logic [3:0]  BEN_NONE   = 4'h0;

    typedef enum logic [3:0] {
        K_BAD,
        K_ADD_MEM_BYTE,
        K_ADD_MEM_WORD,
        K_ADD_MEM_DWORD,
        K_ADD_REG,
        K_ADD_REG_MASKED,
        K_RTM_BYTE,
        K_RTM_HALF,
        K_RTM_WORD,
        K_RTM_DWORD
    } fau_kind_t;

    // condition code, exc = first bit ... eq = fourth bit
    typedef struct packed {
        logic exc;
        logic gt;
        logic lt;
        logic eq;
    } fau_cc_t;

    typedef struct packed {
        logic [31:0] instr;
        logic [31:0] regA;      // R or destination register
        logic [31:0] regB;      // R+1 or source register
        logic [31:0] maskReg;   // mask register
        logic [31:0] memHi;     // addressed word (more significant of a pair)
        logic [31:0] memLo;     // second word of a doubleword
    } fau_req_t;

    typedef struct packed {
        logic        done;
        logic        badOp;
        logic        busy;
        logic [1:0]  regWe;     // [0] register R, [1] register R+1
        logic [2:0]  regNum;
        logic [31:0] regWdA;
        logic [31:0] regWdB;
        logic [1:0]  memWe;     // [1] addressed word, [0] second word
        logic [3:0]  memByteEn; // lanes of the addressed word, [3] = byte 0
        logic [31:0] memWdHi;
        logic [31:0] memWdLo;
        fau_cc_t     cc;
    } fau_rsp_t;

endpackage : fau_pkg
